// file: cee_defs.svh
// Opcode field positions, encodings and codes for the conditional execution evaluator.
`ifndef CEE_DEFS_SVH
`define CEE_DEFS_SVH

// Instruction word layout.
`define CEE_INSTR_W 16
`define CEE_OP_HI 15
`define CEE_OP_LO 12
`define CEE_KIND_HI 11
`define CEE_KIND_LO 10
`define CEE_SEL_HI 9
`define CEE_SEL_LO 8
`define CEE_STATE_HI 7
`define CEE_STATE_LO 4
`define CEE_MASK_HI 3
`define CEE_MASK_LO 0

// Leading opcode nibble of all conditional transfers.
`define CEE_OP_COND 4'hE

// Transfer kind in bits 11:10.
`define CEE_KIND_BRANCH 2'h0
`define CEE_KIND_CALL 2'h2
`define CEE_KIND_RETURN 2'h3

// Branch condition select encodings.
`define CEE_SEL_PIN_LOW 2'h0
`define CEE_SEL_TC_SET 2'h1
`define CEE_SEL_TC_CLEAR 2'h2
`define CEE_SEL_NONE 2'h3

// Flag condition field bit positions (zero, negative, overflow, carry).
`define CEE_FLAG_Z 3
`define CEE_FLAG_L 2
`define CEE_FLAG_V 1
`define CEE_FLAG_C 0

// Reset value of the synchronised test pin level (pin idles high).
`define CEE_PIN_RST 1'h1

`endif

// file: cee_pkg.sv
// Types shared by the conditional execution evaluator.
package cee_pkg;

	typedef enum logic [3:0] {
		CEE_KIND_NONE = 4'h1,
		CEE_KIND_BR = 4'h2,
		CEE_KIND_CL = 4'h4,
		CEE_KIND_RT = 4'h8
	} cee_kind_t;

endpackage

// file: cee_pin_sync.sv
// Three-stage synchroniser for the external test pin with agreement filter.
`include "cee_defs.svh"

module cee_pin_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Pin and clean level
	input wire logic pinAsync,
	output logic pinLevel
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	logic level_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_reg <= `CEE_PIN_RST;
			stage2_reg <= `CEE_PIN_RST;
			stage3_reg <= `CEE_PIN_RST;
		end else begin
			stage1_reg <= pinAsync;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A change is accepted only once the last two stages agree.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			level_reg <= `CEE_PIN_RST;
		end else if (stage2_reg == stage3_reg) begin
			level_reg <= stage3_reg;
		end
	end

	assign pinLevel = level_reg;

endmodule

// file: cee_evaluator.sv
// Condition evaluation for conditional branch, call and return instructions.
// An instruction presented with instrValid is judged in one cycle; the verdict is
// registered and shown with the decisionValid pulse on the following edge.
`include "cee_defs.svh"

module cee_evaluator #(
	parameter int ACC_W = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Instruction from the decoder
	input wire logic instrValid,
	input wire logic [`CEE_INSTR_W-1:0] instrWord,
	// Datapath state
	input wire logic [ACC_W-1:0] mainSumRegister,
	input wire logic overflowFlag,
	input wire logic carryFlag,
	input wire logic testControlFlag,
	// External test pin, asynchronous
	input wire logic externalTestPin,
	// Verdict
	output logic decisionValid,
	output cee_pkg::cee_kind_t transferKind,
	output logic transferTaken,
	output logic selectMet,
	output logic flagMet,
	output logic conditionalCall
);
	import cee_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Classifies an instruction word; anything else is not a conditional transfer.
	function automatic cee_kind_t decodeKind(input logic [`CEE_INSTR_W-1:0] w);
		cee_kind_t k;
		k = CEE_KIND_NONE;
		if (w[`CEE_OP_HI:`CEE_OP_LO] == `CEE_OP_COND) begin
			case (w[`CEE_KIND_HI:`CEE_KIND_LO])
				`CEE_KIND_BRANCH: k = CEE_KIND_BR;
				`CEE_KIND_CALL: k = CEE_KIND_CL;
				`CEE_KIND_RETURN: k = CEE_KIND_RT;
				default: k = CEE_KIND_NONE;
			endcase
		end
		return k;
	endfunction

	// Evaluates the two-bit branch condition select.
	function automatic logic selectTest(input logic [1:0] sel, input logic pin,
		input logic tc);
		logic r;
		r = 1'b0;
		case (sel)
			`CEE_SEL_PIN_LOW: r = ~pin;
			`CEE_SEL_TC_SET: r = tc;
			`CEE_SEL_TC_CLEAR: r = ~tc;
			`CEE_SEL_NONE: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Test pin synchronisation.

	logic pinLevel;

	cee_pin_sync u_pin_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinAsync(externalTestPin),
		.pinLevel(pinLevel)
	);

	////////////////////////////////////////////////////////////////////////////
	// Combinational evaluation.

	logic [3:0] condVec;
	logic [3:0] maskField;
	logic [3:0] stateField;
	logic [3:0] matchVec;
	logic selectNext;
	logic flagNext;
	cee_kind_t kindNext;

	assign condVec[`CEE_FLAG_Z] = (mainSumRegister == '0);
	assign condVec[`CEE_FLAG_L] = mainSumRegister[ACC_W-1];
	assign condVec[`CEE_FLAG_V] = overflowFlag;
	assign condVec[`CEE_FLAG_C] = carryFlag;

	assign maskField = instrWord[`CEE_MASK_HI:`CEE_MASK_LO];
	assign stateField = instrWord[`CEE_STATE_HI:`CEE_STATE_LO];

	// A condition matches when it equals its required state.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_match
			assign matchVec[gi] = ~(condVec[gi] ^ stateField[gi]);
		end
	endgenerate

	// An empty mask tests no flag, so the flag side cannot veto the select side.
	// Zero-or-positive via any-bit
	assign flagNext = (maskField == 4'h0) | (|(maskField & matchVec));

	assign selectNext = selectTest(instrWord[`CEE_SEL_HI:`CEE_SEL_LO], pinLevel,
		testControlFlag);
	assign kindNext = decodeKind(instrWord);

	////////////////////////////////////////////////////////////////////////////
	// Registered verdict.

	logic valid_reg;
	logic taken_reg;
	logic select_reg;
	logic flag_reg;
	cee_kind_t kind_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= instrValid;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			kind_reg <= CEE_KIND_NONE;
			select_reg <= 1'b0;
			flag_reg <= 1'b0;
			taken_reg <= 1'b0;
		end else if (instrValid) begin
			kind_reg <= kindNext;
			select_reg <= selectNext;
			flag_reg <= flagNext;
			taken_reg <= (kindNext != CEE_KIND_NONE) & selectNext & flagNext;
		end
	end

	assign decisionValid = valid_reg;
	assign transferKind = kind_reg;
	assign transferTaken = taken_reg;
	assign selectMet = select_reg;
	assign flagMet = flag_reg;
	assign conditionalCall = (kind_reg == CEE_KIND_CL);

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_verdict_latency: assert property (instrValid |=> decisionValid)
		else $error("Verdict did not follow the instruction by one cycle.");

	a_valid_pulse: assert property (!instrValid |=> !decisionValid)
		else $error("Verdict valid without an instruction.");

	a_verdict_hold: assert property (!instrValid |=> $stable(transferKind) &&
		$stable(transferTaken) && $stable(selectMet) && $stable(flagMet))
		else $error("Verdict changed without an instruction.");

	a_select_decode: assert property (decisionValid |-> selectMet ==
		(($past(instrWord[9:8]) == 2'h0 && !$past(pinLevel)) ||
		($past(instrWord[9:8]) == 2'h1 && $past(testControlFlag)) ||
		($past(instrWord[9:8]) == 2'h2 && !$past(testControlFlag)) ||
		$past(instrWord[9:8]) == 2'h3))
		else $error("Select condition decoded wrongly.");

	a_zero_cond: assert property (decisionValid &&
		$past(instrWord[7:0]) == 8'h88 |-> flagMet == ($past(mainSumRegister) == '0))
		else $error("Zero condition misjudged.");

	a_mask_empty: assert property (decisionValid &&
		$past(instrWord[3:0]) == 4'h0 |-> flagMet)
		else $error("Empty mask did not pass the flag test.");

	a_carry_state: assert property (decisionValid &&
		$past(instrWord[3:0]) == 4'h1 |-> flagMet == ($past(carryFlag) == $past(instrWord[4])))
		else $error("Carry state compare wrong.");

	a_not_negative: assert property (decisionValid &&
		$past(instrWord[7:0]) == 8'h8C |-> flagMet == !$past(mainSumRegister[ACC_W-1]))
		else $error("Not-below-zero test wrong.");

	a_flag_veto: assert property (decisionValid && !flagMet |-> !transferTaken
		##1 (!decisionValid || transferTaken == (selectMet && flagMet &&
		transferKind != CEE_KIND_NONE)))
		else $error("Failed flag test still transferred.");

	a_call_decode: assert property (decisionValid |-> conditionalCall ==
		($past(instrWord[15:12]) == 4'hE && $past(instrWord[11:10]) == 2'h2))
		else $error("Conditional call decode wrong.");

	a_both_tests: assert property (decisionValid |-> transferTaken ==
		(selectMet && flagMet && transferKind != CEE_KIND_NONE))
		else $error("Transfer taken without both tests.");

	a_overflow_state: assert property (decisionValid &&
		$past(instrWord[3:0]) == 4'h2 |-> flagMet == ($past(overflowFlag) == $past(instrWord[5])))
		else $error("Overflow state compare wrong.");

endmodule

// file: cee_evaluator_tb.sv
// Self-checking testbench for the conditional execution evaluator.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cee_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [31:0] mainSumRegister = 32'h0;
	logic overflowFlag = 1'b0;
	logic carryFlag = 1'b0;
	logic testControlFlag = 1'b0;
	logic externalTestPin = 1'b1;
	logic pinNow = 1'b1;
	logic decisionValid, transferTaken, selectMet, flagMet, conditionalCall;
	cee_kind_t transferKind;
	int errTotal = 0;
	int testsRun = 0;

	always #4 clock = ~clock;

	cee_evaluator i_cee_evaluator (.clock(clock), .sys_rst(sys_rst), .instrValid(instrValid),
		.instrWord(instrWord), .mainSumRegister(mainSumRegister), .overflowFlag(overflowFlag),
		.carryFlag(carryFlag), .testControlFlag(testControlFlag),
		.externalTestPin(externalTestPin), .decisionValid(decisionValid),
		.transferKind(transferKind), .transferTaken(transferTaken), .selectMet(selectMet),
		.flagMet(flagMet), .conditionalCall(conditionalCall));

	////////////////////////////////////////////////////////////////////////////////
	task chk_bit(input logic got, input logic exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("BAD %0t bit got %b expected %b", $time, got, exp);
		end
	endtask

	task chk_kind(input cee_kind_t got, input cee_kind_t exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("BAD %0t kind got %h expected %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One word through the evaluator, judged against a model built from the field layout.
	task issue(input logic [15:0] w, input logic [31:0] acc, input logic v, c, tc);
		logic [3:0] cond;
		logic fm, sm, isCond;
		cee_kind_t ek;
		@(posedge clock);
		instrValid <= 1'b1;
		instrWord <= w;
		mainSumRegister <= acc;
		overflowFlag <= v;
		carryFlag <= c;
		testControlFlag <= tc;
		@(posedge clock);
		instrValid <= 1'b0;
		#1;
		cond = {acc == 32'h0, acc[31], v, c};
		fm = (w[3:0] == 4'h0) || |(w[3:0] & ~(cond ^ w[7:4]));
		sm = (w[9:8] == 2'h0) ? !pinNow : (w[9:8] == 2'h1) ? tc : (w[9:8] == 2'h2) ? !tc : 1'b1;
		isCond = (w[15:12] == 4'hE) && (w[11:10] != 2'h1);
		ek = !isCond ? CEE_KIND_NONE : (w[11:10] == 2'h0) ? CEE_KIND_BR :
			(w[11:10] == 2'h2) ? CEE_KIND_CL : CEE_KIND_RT;
		chk_bit(decisionValid, 1'b1);
		chk_kind(transferKind, ek);
		chk_bit(conditionalCall, ek == CEE_KIND_CL);
		chk_bit(transferTaken, isCond && sm && fm);
		if (isCond) begin
			chk_bit(selectMet, sm);
			chk_bit(flagMet, fm);
		end
		@(posedge clock);
		#1;
		chk_bit(decisionValid, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task scen_select;
		for (int s = 0; s < 4; s++) begin
			for (int t = 0; t < 2; t++) begin
				issue({6'h38, s[1:0], 8'h00}, 32'h5, 1'b0, 1'b0, t[0]);
			end
		end
		@(posedge clock);
		externalTestPin <= 1'b0;
		pinNow = 1'b0;
		// The synchroniser needs a few edges before the new level is used.
		repeat (6) @(posedge clock);
		issue(16'hE000, 32'h5, 1'b0, 1'b0, 1'b0);
		@(posedge clock);
		externalTestPin <= 1'b1;
		pinNow = 1'b1;
		repeat (6) @(posedge clock);
		issue(16'hE000, 32'h5, 1'b0, 1'b0, 1'b0);
	endtask

	task scen_flags;
		static logic [15:0] words [10] = '{16'hE38C, 16'hE304, 16'hE3CC, 16'hE344, 16'hE311,
			16'hE301, 16'hE302, 16'hE322, 16'hE388, 16'hE308};
		static logic [31:0] accs [4] = '{32'h0, 32'h5, 32'h80000000, 32'h7FFFFFFF};
		foreach (words[i]) begin
			foreach (accs[j]) begin
				for (int f = 0; f < 4; f++) begin
					issue(words[i], accs[j], f[1], f[0], 1'b0);
				end
			end
		end
	endtask

	task scen_kinds;
		static logic [15:0] words [6] = '{16'hEB8C, 16'hEF8C, 16'hE78C, 16'h738C, 16'hE98C,
			16'hE58C};
		foreach (words[i]) begin
			issue(words[i], 32'h5, 1'b0, 1'b0, 1'b0);
			issue(words[i], 32'h5, 1'b0, 1'b0, 1'b1);
		end
	endtask

	// A reset in mid-run must clear a held verdict and leave the block usable at once.
	task scen_reset;
		issue(16'hEB8C, 32'h5, 1'b0, 1'b0, 1'b0);
		@(posedge clock);
		sys_rst <= 1'b1;
		#1;
		chk_bit(decisionValid, 1'b0);
		chk_kind(transferKind, CEE_KIND_NONE);
		chk_bit(transferTaken, 1'b0);
		chk_bit(conditionalCall, 1'b0);
		chk_bit(selectMet, 1'b0);
		chk_bit(flagMet, 1'b0);
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		issue(16'hEB8C, 32'h5, 1'b0, 1'b0, 1'b0);
	endtask

	task scen_back_to_back;
		@(posedge clock);
		instrValid <= 1'b1;
		instrWord <= 16'hE388;
		mainSumRegister <= 32'h0;
		@(posedge clock);
		mainSumRegister <= 32'h5;
		#1;
		chk_bit(transferTaken, 1'b1);
		@(posedge clock);
		instrValid <= 1'b0;
		#1;
		chk_bit(decisionValid, 1'b1);
		chk_bit(transferTaken, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clock);
		#1;
		chk_bit(decisionValid, 1'b0);
		chk_kind(transferKind, CEE_KIND_NONE);
		chk_bit(transferTaken, 1'b0);
		chk_bit(selectMet, 1'b0);
		chk_bit(flagMet, 1'b0);
		chk_bit(conditionalCall, 1'b0);
		@(posedge clock);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clock);
		scen_select();
		scen_flags();
		scen_kinds();
		scen_reset();
		scen_back_to_back();
		print_verdict();
	end

	// The run needs well under 1000 cycles; this span leaves a wide margin.
	initial begin
		#60000;
		errTotal++;
		print_verdict();
	end
endmodule
